/* hw/emw_pkg.sv */
// package: constants for the external memory width/wait/bus-request slice
// assumes: single bus clock, APB register access, one config word
// Functional notes
// (RULE_01) with wait enabled, output enable stays low while external wait is low
// (RULE_02) external wait is first sampled at access cycle count minus one
// (RULE_03) output enable rises on the clock after wait is sampled high
// (RULE_04) write strobe is stretched and released exactly like output enable
// (RULE_05) external bus request low is answered by driving bus grant low
// (RULE_06) while grant is low, address, data and control pins float
// (RULE_07) request released makes grant rise, then the bus may be driven again
// (RULE_08) banks 2..7 lane mode bits 11,15,..31: 0 write-byte, 1 byte enables
// (RULE_09) banks 3..7 wait enable bits 14,18,..30: 0 ignore, 1 honour wait
// (RULE_10) banks 3..7 width fields 13:12..29:28: 00 8, 01 16, 10 32 bit
// (RULE_11) config word at 0x14000000 resets to all zeros
// (RULE_12) two-bank SDRAM bank select is A20..A24 for 2MB..32MB banks
// (RULE_13) four-bank SDRAM bank select is A[22:21],A[23:22],A[24:23] for 8..32MB
// (RULE_14) all cycle counts are measured in bus clock periods
// (RULE_15) byte enable is AND of active-low write-byte enable and output enable
// (RULE_16) external master holds request for its tenure, drives only when granted
package emw_pkg;
  localparam logic [31:0] CFG_ADDR = 32'h1400_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] ACC_STAT_ADDR = 32'h1400_0040;
  localparam int BANK_LO = 2;
  localparam int BANK_HI = 7;
  localparam int FIELD_BASE = 8;
  localparam int FIELD_STEP = 4;
  localparam int WIDTH_OFS = 0;
  localparam int WAIT_OFS = 2;
  localparam int LANE_OFS = 3;
  localparam int TACC_W = 4;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [2:0] SIZE_2MB = 3'h0;
  localparam logic [2:0] SIZE_4MB = 3'h1;
  localparam logic [2:0] SIZE_8MB = 3'h2;
  localparam logic [2:0] SIZE_16MB = 3'h3;
  localparam logic [2:0] SIZE_32MB = 3'h4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_WAIT = 2'b10,
    ST_OFF = 2'b11
  } emw_state_t;
endpackage : emw_pkg

/* hw/emw_apb_regs.sv */
// APB slave for the width/wait config word plus a read-only status word
// assumes: APB master per protocol, same clock; zero-wait answers
`timescale 1ns/1ps
module emw_apb_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] status,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] cfg
);
  logic [31:0] next_cfg;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic hit_cfg;
  logic hit_stat;

  // decode, write and read data; unmapped addresses read zero with an error
  always_comb begin
    hit_cfg = (paddr == emw_pkg::CFG_ADDR);
    hit_stat = (paddr == emw_pkg::ACC_STAT_ADDR);
    next_cfg = cfg;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = hit_cfg ? cfg : (hit_stat ? status : 32'h0000_0000);
      next_pslverr = !(hit_cfg || hit_stat);
    end
    if (psel && penable && pwrite && hit_cfg) begin
      next_cfg = pwdata; // RULE_11
    end
  end

  // pready held high: every access finishes in its first access cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg <= emw_pkg::CFG_RESET; // RULE_11
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      cfg <= next_cfg;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= 1'b1;
    end
  end
endmodule : emw_apb_regs

/* hw/emw_sync.sv */
// two-flop synchroniser for a pin level
// assumes: input asynchronous to clk; reset value given by parameter
`timescale 1ns/1ps
module emw_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d,
  output logic q
);
  logic meta;
  // first flop feeds only the second flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : emw_sync

/* hw/emw_ctrl.sv */
// top: strobe timing with external wait, byte-lane mode, bus request/grant,
// SDRAM bank-select address mapping
// assumes: internal master gives a one-cycle start pulse with bank, direction,
// access count and byte mask; pins resolved by the outer pad ring
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module emw_ctrl #(
  parameter int ADDR_W = 25
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REQ_START,
  input wire logic [2:0] REQ_BANK,
  input wire logic REQ_WRITE,
  input wire logic [3:0] REQ_TACC,
  input wire logic [3:0] REQ_BYTES,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [31:0] REQ_WDATA,
  input wire logic [2:0] SDRAM_SIZE,
  input wire logic SDRAM_FOUR_BANK,
  output logic REQ_DONE,
  output logic REQ_BUSY,
  output logic [1:0] REQ_WIDTH,
  output logic [1:0] SDRAM_BANK_SEL,
  input wire logic EXT_WAIT_N,
  input wire logic BUS_REQUEST_N,
  output logic BUS_GRANT_N,
  output logic OUTPUT_ENABLE_N,
  output logic WRITE_ENABLE_N,
  output logic [3:0] WRITE_BYTE_ENABLE_N,
  output logic [3:0] BYTE_ENABLE_N,
  output logic [7:0] CHIP_SELECT_N,
  output logic [ADDR_W-1:0] ADDR_O,
  output logic [31:0] DATA_O,
  output logic BUS_OE
);
  logic [31:0] cfg;
  logic [31:0] status;
  logic wait_s;
  logic breq_s;
  emw_pkg::emw_state_t state;
  emw_pkg::emw_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [2:0] bank;
  logic [2:0] next_bank;
  logic wr;
  logic next_wr;
  logic [3:0] bytes;
  logic [3:0] next_bytes;
  logic oe_n;
  logic we_n;
  logic [3:0] wbe_n;
  logic [3:0] be_n;
  logic next_grant_n;
  logic next_done;
  logic [ADDR_W-1:0] next_addr;
  logic [31:0] next_data;
  logic [1:0] next_width;
  logic [1:0] next_bsel;

  // per-bank field lookup; banks 0 and 1 have no fields here
  function automatic logic cfg_bit(input logic [31:0] c, input logic [2:0] b,
                                   input int ofs);
    int pos;
    pos = emw_pkg::FIELD_BASE + emw_pkg::FIELD_STEP * (int'(b) - 2) + ofs;
    if (b < 3'(emw_pkg::BANK_LO)) cfg_bit = 1'b0;
    else cfg_bit = c[pos];
  endfunction : cfg_bit

  // wait enable: bank 2 bit excluded from this slice
  function automatic logic wait_en(input logic [31:0] c, input logic [2:0] b);
    wait_en = (b >= 3'h3) && cfg_bit(c, b, emw_pkg::WAIT_OFS); // RULE_09
  endfunction : wait_en

  emw_apb_regs u_regs (
    .clk(CLK),
    .resetn(RESETN),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .status(status),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .cfg(cfg)
  );

  // pins from the outside world pass two flops before use
  emw_sync #(.INIT(1'b1)) u_wait_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d(EXT_WAIT_N),
    .q(wait_s)
  );
  emw_sync #(.INIT(1'b1)) u_breq_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d(BUS_REQUEST_N),
    .q(breq_s)
  );

  // status word shows engine state and grant
  assign status = {27'h0, state == emw_pkg::ST_WAIT, !BUS_GRANT_N,
                   REQ_BUSY, 2'(state)};

  // access sequencer, counts in bus clocks
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bank = bank;
    next_wr = wr;
    next_bytes = bytes;
    next_done = 1'b0;
    next_grant_n = BUS_GRANT_N;
    unique case (state)
      emw_pkg::ST_IDLE: begin
        if (!breq_s) begin
          next_grant_n = 1'b0; // RULE_05
          next_state = emw_pkg::ST_OFF;
        end else if (REQ_START) begin
          next_bank = REQ_BANK;
          next_wr = REQ_WRITE;
          next_bytes = REQ_BYTES;
          next_cnt = (REQ_TACC == 4'h0) ? 4'h1 : REQ_TACC; // RULE_14
          // the wait pin needs two clocks through the synchroniser, so a
          // waited access lasts at least three clocks or it reads stale wait
          if (wait_en(cfg, REQ_BANK) && REQ_TACC < 4'h3) begin
            next_cnt = 4'h3; // RULE_01
          end
          next_state = emw_pkg::ST_ACCESS;
        end
      end
      emw_pkg::ST_ACCESS: begin
        // sampling starts when one cycle of tacc remains
        if (cnt <= 4'h2 && wait_en(cfg, bank)) begin
          next_cnt = 4'h1; // RULE_02
          next_state = emw_pkg::ST_WAIT;
        end else if (cnt == 4'h1) begin
          next_done = 1'b1;
          next_state = emw_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      emw_pkg::ST_WAIT: begin
        // strobe held while wait low, released next clock after high
        if (wait_s) begin
          next_done = 1'b1; // RULE_03
          next_state = emw_pkg::ST_IDLE;
        end
      end
      emw_pkg::ST_OFF: begin
        if (breq_s) begin
          next_grant_n = 1'b1; // RULE_07
          next_state = emw_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state <= emw_pkg::ST_IDLE;
      cnt <= 4'h0;
      bank <= 3'h0;
      wr <= 1'b0;
      bytes <= 4'h0;
      REQ_DONE <= 1'b0;
      BUS_GRANT_N <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bank <= next_bank;
      wr <= next_wr;
      bytes <= next_bytes;
      REQ_DONE <= next_done;
      BUS_GRANT_N <= next_grant_n;
    end
  end

  // strobes: low during access and wait stretch
  always_comb begin
    oe_n = 1'b1;
    we_n = 1'b1;
    if (next_state == emw_pkg::ST_ACCESS || next_state == emw_pkg::ST_WAIT)
    begin
      oe_n = next_wr; // RULE_01
      we_n = !next_wr; // RULE_04
    end
    wbe_n = we_n ? 4'hF : ~next_bytes;
    // lane mode 1 turns pins into byte enables for upper/lower SRAM
    if (cfg_bit(cfg, next_bank, emw_pkg::LANE_OFS)) begin // RULE_08
      be_n = (oe_n ? 4'hF : 4'h0) & (we_n ? 4'hF : ~next_bytes); // RULE_15
    end else begin
      be_n = wbe_n;
    end
  end

  // width and SDRAM bank select decode
  always_comb begin
    next_width = emw_pkg::WIDTH_8;
    if (REQ_BANK >= 3'h3) begin
      next_width = cfg[emw_pkg::FIELD_BASE + emw_pkg::FIELD_STEP *
                       (int'(REQ_BANK) - 2) +: 2]; // RULE_10
    end
    next_bsel = 2'h0;
    if (SDRAM_FOUR_BANK) begin // RULE_13
      unique case (SDRAM_SIZE)
        emw_pkg::SIZE_8MB: next_bsel = REQ_ADDR[22:21];
        emw_pkg::SIZE_16MB: next_bsel = REQ_ADDR[23:22];
        emw_pkg::SIZE_32MB: next_bsel = REQ_ADDR[24:23];
        default: next_bsel = 2'h0;
      endcase
    end else begin // RULE_12
      unique case (SDRAM_SIZE)
        emw_pkg::SIZE_2MB: next_bsel = {1'b0, REQ_ADDR[20]};
        emw_pkg::SIZE_4MB: next_bsel = {1'b0, REQ_ADDR[21]};
        emw_pkg::SIZE_8MB: next_bsel = {1'b0, REQ_ADDR[22]};
        emw_pkg::SIZE_16MB: next_bsel = {1'b0, REQ_ADDR[23]};
        emw_pkg::SIZE_32MB: next_bsel = {1'b0, REQ_ADDR[24]};
        default: next_bsel = 2'h0;
      endcase
    end
    next_addr = (REQ_START && state == emw_pkg::ST_IDLE) ? REQ_ADDR : ADDR_O;
    next_data = (REQ_START && state == emw_pkg::ST_IDLE) ? REQ_WDATA : DATA_O;
  end

  // registered pins; bus released while granted to outside master
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      OUTPUT_ENABLE_N <= 1'b1;
      WRITE_ENABLE_N <= 1'b1;
      WRITE_BYTE_ENABLE_N <= 4'hF;
      BYTE_ENABLE_N <= 4'hF;
      CHIP_SELECT_N <= 8'hFF;
      ADDR_O <= '0;
      DATA_O <= 32'h0000_0000;
      BUS_OE <= 1'b0;
      REQ_BUSY <= 1'b0;
      REQ_WIDTH <= 2'h0;
      SDRAM_BANK_SEL <= 2'h0;
    end else begin
      OUTPUT_ENABLE_N <= oe_n;
      WRITE_ENABLE_N <= we_n;
      WRITE_BYTE_ENABLE_N <= wbe_n;
      BYTE_ENABLE_N <= be_n;
      CHIP_SELECT_N <= (oe_n && we_n) ? 8'hFF : ~(8'h01 << next_bank);
      ADDR_O <= next_addr;
      DATA_O <= next_data;
      BUS_OE <= next_grant_n; // RULE_06
      REQ_BUSY <= (next_state == emw_pkg::ST_ACCESS) ||
                  (next_state == emw_pkg::ST_WAIT);
      REQ_WIDTH <= next_width;
      SDRAM_BANK_SEL <= next_bsel;
    end
  end
endmodule : emw_ctrl

/* tb/emw_ctrl_assertions.sv */
// checker: port-level timing of strobes, grant and register bus
// assumes: bound to emw_ctrl, one bus clock, sync active-low reset
`timescale 1ns/1ps
module emw_ctrl_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic REQ_DONE,
  input wire logic REQ_BUSY,
  input wire logic BUS_REQUEST_N,
  input wire logic BUS_GRANT_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic [7:0] CHIP_SELECT_N,
  input wire logic BUS_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // request pins pass a synchroniser, so allow a few cycles
  sequence s_req_held;
    (!BUS_REQUEST_N && !REQ_BUSY) [*5];
  endsequence
  sequence s_rel_held;
    BUS_REQUEST_N [*4];
  endsequence
  a_grant_given: assert property (s_req_held |-> !BUS_GRANT_N)
    else $error("grant missing");
  a_grant_floats: assert property (!BUS_GRANT_N |-> !BUS_OE
    && OUTPUT_ENABLE_N && WRITE_ENABLE_N) else $error("bus driven");
  a_grant_dropped: assert property (s_rel_held |-> BUS_GRANT_N)
    else $error("grant stuck");
  a_oe_end_done: assert property ($rose(OUTPUT_ENABLE_N) |-> REQ_DONE)
    else $error("read strobe end without done");
  a_we_end_done: assert property ($rose(WRITE_ENABLE_N) |-> REQ_DONE)
    else $error("write strobe end without done");
  a_strobe_busy: assert property ((!OUTPUT_ENABLE_N ||
    !WRITE_ENABLE_N) |-> REQ_BUSY && !(&CHIP_SELECT_N))
    else $error("strobe outside access");
  a_done_pulse: assert property (REQ_DONE |=> !REQ_DONE)
    else $error("done too long");
  a_apb_ready: assert property (PSEL && PENABLE |-> PREADY)
    else $error("apb wait");
  a_apb_unmapped: assert property (PSEL && PENABLE &&
    PADDR != emw_pkg::CFG_ADDR && PADDR != emw_pkg::ACC_STAT_ADDR
    |-> PSLVERR) else $error("no slave error");
endmodule : emw_ctrl_chk
bind emw_ctrl emw_ctrl_chk u_emw_ctrl_chk (.*);

/* tb/emw_ext_mem.sv */
// partner: slow external memory driving wait, plus external bus master
// assumes: selects from emw_ctrl, same bus clock
`timescale 1ns/1ps
module emw_ext_mem (
  input wire logic clk,
  input wire logic [7:0] cs_n,
  input wire logic [3:0] hold,
  input wire logic xreq,
  output logic wait_n,
  output logic breq_n
);
  logic [3:0] cnt;
  // wait has a pull-up, so a deselected device reads high
  initial begin
    cnt = 4'h0;
    breq_n = 1'h1;
  end
  // count selected cycles; saturates to avoid a rewrap
  always @(posedge clk) begin
    if (&cs_n) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + {3'h0, ~&cnt};
    end
  end
  // wait follows the select at once, as a slow device pulls it right away
  assign wait_n = (&cs_n) || (cnt >= hold);
  // request held for the whole tenure, no bus driving of its own
  always @(posedge clk) begin
    breq_n <= !xreq;
  end
endmodule : emw_ext_mem

/* tb/testbench.sv */
// testbench: config word, bank select, strobes with wait, bus grant
// assumes: emw_ctrl, partner model and bound checker
`timescale 1ns/1ps
module testbench;
  logic CLK, PREADY, PSLVERR, REQ_DONE, REQ_BUSY, BUS_OE, err;
  logic RESETN = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic REQ_START = 1'h0, REQ_WRITE = 1'h0, SDRAM_FOUR_BANK = 1'h0;
  logic xreq = 1'h0, EXT_WAIT_N, BUS_REQUEST_N, BUS_GRANT_N;
  logic OUTPUT_ENABLE_N, WRITE_ENABLE_N;
  logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, REQ_WDATA = 32'h0;
  logic [31:0] PRDATA, DATA_O, rd, cfg;
  logic [2:0] REQ_BANK = 3'h0, SDRAM_SIZE = 3'h0;
  logic [3:0] REQ_TACC = 4'h0, REQ_BYTES = 4'h0, hold = 4'h0;
  logic [3:0] WRITE_BYTE_ENABLE_N, BYTE_ENABLE_N;
  logic [1:0] REQ_WIDTH, SDRAM_BANK_SEL;
  logic [7:0] CHIP_SELECT_N;
  logic [24:0] REQ_ADDR = 25'h0, ADDR_O;
  int error_cnt = 0, checked = 0, n;
  typedef struct {logic [2:0] b, s; logic f; logic [24:0] a;
    logic [1:0] e;} emw_row_t;
  // bank, sdram size, four-bank parts, address, expected select
  emw_row_t rows [10] = '{'{3'h2, 3'h0, 1'h0, 25'h0100000, 2'h1},
    '{3'h3, 3'h1, 1'h0, 25'h0200000, 2'h1},
    '{3'h4, 3'h1, 1'h0, 25'h0100000, 2'h0},
    '{3'h5, 3'h2, 1'h0, 25'h0400000, 2'h1},
    '{3'h6, 3'h3, 1'h0, 25'h0800000, 2'h1},
    '{3'h7, 3'h4, 1'h0, 25'h1000000, 2'h1},
    '{3'h3, 3'h2, 1'h1, 25'h0400000, 2'h2},
    '{3'h4, 3'h2, 1'h1, 25'h0200000, 2'h1},
    '{3'h5, 3'h3, 1'h1, 25'h0C00000, 2'h3},
    '{3'h6, 3'h4, 1'h1, 25'h1000000, 2'h2}};
  emw_ctrl u_emw_ctrl (.*);
  emw_ext_mem u_emw_ext_mem (.clk(CLK), .cs_n(CHIP_SELECT_N),
    .hold(hold), .xreq(xreq), .wait_n(EXT_WAIT_N), .breq_n(BUS_REQUEST_N));
  // 50 MHz bus clock
  initial begin
    CLK = 1'h0;
    forever #10 CLK = ~CLK;
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic tmo;
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop();
  endtask : tmo
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'h1 && n < 20);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (n >= 20) tmo();
  endtask : apb
  // one access; lanes watched each cycle, latency bounded by lo..hi
  task automatic acc(input logic [2:0] b, input logic w,
    input logic [3:0] t, y, h, input int lo, hi);
    int lat;
    logic [3:0] ny;
    logic [7:0] cs_e;
    ny = ~y;
    cs_e = ~(8'h01 << b);
    @(posedge CLK);
    REQ_START <= 1'h1;
    REQ_BANK <= b;
    REQ_WRITE <= w;
    REQ_TACC <= t;
    REQ_BYTES <= y;
    hold <= h;
    @(posedge CLK);
    REQ_START <= 1'h0;
    lat = 0;
    do begin
      @(posedge CLK);
      #1;
      lat++;
      if (b == 3'h3)
        chk(BYTE_ENABLE_N, WRITE_BYTE_ENABLE_N & {4{OUTPUT_ENABLE_N}});
      else if (!WRITE_ENABLE_N)
        chk(WRITE_BYTE_ENABLE_N, ny);
      if (b != 3'h3)
        chk(BYTE_ENABLE_N, WRITE_BYTE_ENABLE_N);
      if (!OUTPUT_ENABLE_N || !WRITE_ENABLE_N)
        chk(CHIP_SELECT_N, cs_e);
    end while (REQ_DONE !== 1'h1 && lat < 40);
    chk(lat >= lo && lat <= hi, 1'h1);
  endtask : acc
  task automatic wait_grant(input logic v);
    n = 0;
    while (BUS_GRANT_N !== v && n < 10) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 10) tmo();
  endtask : wait_grant
  // main sequence: reset, registers, table, accesses, bus handover
  initial begin
    cfg = 32'h2106_9200;
    repeat (3) @(posedge CLK);
    RESETN <= 1'h1;
    repeat (2) @(posedge CLK);
    apb(1'h0, emw_pkg::CFG_ADDR, 32'h0);
    chk(rd, emw_pkg::CFG_RESET);
    apb(1'h1, emw_pkg::CFG_ADDR, cfg);
    apb(1'h0, emw_pkg::CFG_ADDR, 32'h0);
    chk(rd, cfg);
    apb(1'h0, 32'h1400_0004, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK);
      REQ_BANK <= rows[i].b;
      SDRAM_SIZE <= rows[i].s;
      SDRAM_FOUR_BANK <= rows[i].f;
      REQ_ADDR <= rows[i].a;
      repeat (3) @(posedge CLK);
      chk(SDRAM_BANK_SEL, rows[i].e);
      chk(REQ_WIDTH, rows[i].b < 3 ? 2'h0 : cfg[rows[i].b*4+1 -: 2]);
    end
    acc(3'h5, 1'h0, 4'h3, 4'hF, 4'h0, 3, 3);
    acc(3'h5, 1'h0, 4'h4, 4'hF, 4'h8, 4, 4);
    acc(3'h4, 1'h0, 4'h5, 4'hF, 4'h0, 5, 6);
    acc(3'h4, 1'h0, 4'h3, 4'hF, 4'h8, 10, 15);
    acc(3'h4, 1'h1, 4'h2, 4'h6, 4'h6, 8, 13);
    acc(3'h3, 1'h0, 4'h2, 4'hF, 4'h0, 2, 2);
    acc(3'h3, 1'h1, 4'h1, 4'h9, 4'h0, 1, 1);
    acc(3'h6, 1'h1, 4'h0, 4'h3, 4'h0, 1, 1);
    @(posedge CLK);
    xreq <= 1'h1;
    wait_grant(1'h0);
    chk(BUS_OE, 1'h0);
    // status word: state off (3) and granted bit
    apb(1'h0, emw_pkg::ACC_STAT_ADDR, 32'h0);
    chk(rd, 32'h0000_000B);
    // a start while granted must not move the address or data pins
    REQ_START <= 1'h1;
    REQ_ADDR <= 25'h00ABCDE;
    REQ_WDATA <= 32'h5A5A_A5A5;
    @(posedge CLK);
    REQ_START <= 1'h0;
    repeat (3) @(posedge CLK);
    chk(REQ_BUSY, 1'h0);
    chk(ADDR_O, rows[9].a);
    chk(DATA_O, 32'h0000_0000);
    xreq <= 1'h0;
    wait_grant(1'h1);
    chk(BUS_OE, 1'h1);
    acc(3'h6, 1'h1, 4'h1, 4'hF, 4'h0, 1, 1);
    chk(ADDR_O, 25'h00ABCDE);
    chk(DATA_O, 32'h5A5A_A5A5);
    // mid-run reset must bring the config word back to zero
    @(posedge CLK);
    RESETN <= 1'h0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'h1;
    repeat (2) @(posedge CLK);
    apb(1'h0, emw_pkg::CFG_ADDR, 32'h0);
    chk(rd, emw_pkg::CFG_RESET);
    report_and_stop();
  end
endmodule : testbench
